//--- trpc_pkg.sv
package trpc_pkg;

   // ****************************************
   // Bus and counter widths
   // ****************************************
   localparam int CLK_MHZ = 100;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int CNT_W = 16;

   // ****************************************
   // Register offsets and reset values
   // ****************************************
   localparam logic [7:0] ADDR_TX_RAMP = 8'h52;
   localparam logic [7:0] ADDR_SYNTH = 8'h53;
   localparam logic [7:0] ADDR_CAL = 8'h55;
   localparam logic [7:0] ADDR_MODEM = 8'h56;
   localparam logic [7:0] RST_TX_RAMP = 8'h00;
   localparam logic [7:0] RST_SYNTH = 8'h52;
   localparam logic [7:0] RST_CAL = 8'h04;
   localparam logic [7:0] RST_MODEM = 8'h00;
   localparam logic [7:0] CAL_CFG_MASK = 8'h55;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int TXMOD_LSB = 4;
   localparam int TXMOD_W = 3;
   localparam int LDO_LSB = 2;
   localparam int TXRAMP_LSB = 0;
   localparam int RAMP_W = 2;
   localparam int TS_LSB = 3;
   localparam int TS_W = 5;
   localparam int T0_LSB = 0;
   localparam int T0_W = 3;
   localparam int CAL_XTAL_HALF = 6;
   localparam int CAL_ADC_DONE = 5;
   localparam int CAL_FINE_EN = 4;
   localparam int CAL_RC_FORCE = 3;
   localparam int CAL_VCO_DP = 2;
   localparam int CAL_VCO_FORCE = 1;
   localparam int CAL_SKIP_VCO = 0;
   localparam int MT_BCR_BYP = 7;
   localparam int MT_SLIC_BYP = 6;
   localparam int MT_DITHER_TYPE = 5;
   localparam int MT_AFC_POL = 4;
   localparam int MT_REF_SEL = 2;
   localparam int MT_REF_INV = 1;
   localparam int MT_IQ_SWAP = 0;

   // ****************************************
   // Timing
   // ****************************************
   localparam int TXMOD_STEP_NS = 4000;
   localparam int RAMP_STEP_NS = 5000;
   localparam int SETTLE_STEP_NS = 10000;
   localparam int RC_CAL_MS = 2;
   localparam int FINE_PERIOD_S = 30;
   localparam int TXMOD_STEP_CYC = (TXMOD_STEP_NS * CLK_MHZ + 999) / 1000;
   localparam int RAMP_STEP_CYC = (RAMP_STEP_NS * CLK_MHZ + 999) / 1000;
   localparam int SETTLE_STEP_CYC = (SETTLE_STEP_NS * CLK_MHZ + 999) / 1000;
   localparam int RC_CAL_CYC_DEF = RC_CAL_MS * 1000 * CLK_MHZ;
   localparam longint FINE_PERIOD_CYC_DEF = 64'(FINE_PERIOD_S) * 64'd1000000 * 64'(CLK_MHZ);

   // ****************************************
   // Transmit sequencer states
   // ****************************************
   typedef enum logic [1:0] {
      TRPC_TX_IDLE = 2'b00,
      TRPC_TX_DELAY = 2'b01,
      TRPC_TX_MOD = 2'b10,
      TRPC_TX_DOWN = 2'b11
   } trpc_tx_state_type;

endpackage

//--- trpc_tx_ramp_pll_cal_control.sv
// Implementation choice: strobed register access.
`timescale 1ns/100ps
// Functional notes
// - Modulation delay after PA enable, 4us steps
// - RF regulator ramp 5 to 20 us
// - PA ramp-up 5 to 20 us
// - Cold start settling is soft plus post-cal
// - Retune settling 0 to 310 us, 10us steps
// - Post-calibration settling 0 to 70 us
// - Settle timing register resets to 0x52
// - Half-start bit halves crystal wake period
// - ADC calibration done bit reads the adc_cal_done input
// - Fine RC calibration about every 30 s
// - Rising force bit runs 2 ms RC calibration
// - Auto RC calibration on wake timer, WOR
// - Double precision lengthens VCO calibration
// - Force bit runs one VCO calibration
// - Skip bit omits VCO cal idle to TX/RX
// - Bypass bits for BCR and slicer compensation
// - Dither type selects +1/0 or plus-minus one
// - DSM reference 10 MHz or synthesizer
// - Invert DSM reference clock
// - Swap I and Q receive channels
module trpc_tx_ramp_pll_cal_control #(
   parameter int RC_CAL_CYCLES = trpc_pkg::RC_CAL_CYC_DEF,
   parameter longint FINE_PERIOD_CYCLES = trpc_pkg::FINE_PERIOD_CYC_DEF
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic [trpc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [trpc_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [trpc_pkg::DATA_W-1:0] reg_rdata,
   input wire logic tx_request,
   input wire logic chip_idle,
   input wire logic synth_enabled,
   input wire logic idle_to_txrx,
   input wire logic synth_retune,
   input wire logic vco_cal_finished,
   input wire logic adc_cal_done,
   input wire logic rc_osc_enabled,
   input wire logic wakeup_timer_enabled,
   input wire logic wake_on_rx_state,
   output logic pa_enable,
   output logic tx_modulation,
   output logic pa_ramp_busy,
   output logic ldo_ramp_busy,
   output logic synth_settled,
   output logic vco_cal_run,
   output logic vco_cal_double,
   output logic rc_cal_active,
   output logic xtal_wake_half,
   output logic bcr_comp_bypass,
   output logic slicer_comp_bypass,
   output logic dither_symmetric,
   output logic afc_polarity,
   output logic dsm_ref_10mhz,
   output logic dsm_ref_invert,
   output logic iq_swap
);

   localparam int CW = trpc_pkg::CNT_W;
   localparam int RC_W = $clog2(RC_CAL_CYCLES + 1);
   localparam int FINE_W = $clog2(FINE_PERIOD_CYCLES + 1);

   generate
      if (RC_CAL_CYCLES < 2 || FINE_PERIOD_CYCLES < 2 || FINE_W > 63) begin : g_bad
         $error("Calibration cycle counts out of range");
      end
   endgenerate

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
      hit = (a == target);
   endfunction

   function automatic logic [CW-1:0] ramp_cycles(input logic [1:0] code);
      ramp_cycles = CW'((32'(code) + 32'd1) * 32'(trpc_pkg::RAMP_STEP_CYC));
   endfunction

   // ****************************************
   // Register file
   // ****************************************
   logic [7:0] tx_ramp_q, tx_ramp_d;
   logic [7:0] synth_q, synth_d;
   logic [7:0] cal_q, cal_d;
   logic [7:0] modem_q, modem_d;
   logic [7:0] rdata_q, rdata_d;
   logic vco_run_q, vco_run_d;
   logic rc_active_q, rc_active_d;
   logic rc_forced_q, rc_forced_d;
   logic [7:0] cal_view;
   logic [2:0] txmod_f;
   logic [4:0] ts_f;
   logic [2:0] t0_f;

   assign txmod_f = tx_ramp_q[trpc_pkg::TXMOD_LSB +: trpc_pkg::TXMOD_W];
   assign ts_f = synth_q[trpc_pkg::TS_LSB +: trpc_pkg::TS_W];
   assign t0_f = synth_q[trpc_pkg::T0_LSB +: trpc_pkg::T0_W];

   always_comb begin
      cal_view = cal_q;
      cal_view[trpc_pkg::CAL_ADC_DONE] = adc_cal_done;
      cal_view[trpc_pkg::CAL_RC_FORCE] = rc_forced_q;
      cal_view[trpc_pkg::CAL_VCO_FORCE] = vco_run_q;
      tx_ramp_d = tx_ramp_q;
      synth_d = synth_q;
      cal_d = cal_q;
      modem_d = modem_q;
      if (reg_write && hit(reg_addr, trpc_pkg::ADDR_TX_RAMP)) begin
         tx_ramp_d = reg_wdata;
      end else if (reg_write && hit(reg_addr, trpc_pkg::ADDR_SYNTH)) begin
         synth_d = reg_wdata;
      end else if (reg_write && hit(reg_addr, trpc_pkg::ADDR_CAL)) begin
         cal_d = reg_wdata & trpc_pkg::CAL_CFG_MASK;
      end else if (reg_write && hit(reg_addr, trpc_pkg::ADDR_MODEM)) begin
         modem_d = reg_wdata;
      end
      rdata_d = 8'h00;
      if (reg_read && hit(reg_addr, trpc_pkg::ADDR_TX_RAMP)) begin
         rdata_d = tx_ramp_q;
      end else if (reg_read && hit(reg_addr, trpc_pkg::ADDR_SYNTH)) begin
         rdata_d = synth_q;
      end else if (reg_read && hit(reg_addr, trpc_pkg::ADDR_CAL)) begin
         rdata_d = cal_view;
      end else if (reg_read && hit(reg_addr, trpc_pkg::ADDR_MODEM)) begin
         rdata_d = modem_q;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         tx_ramp_q <= trpc_pkg::RST_TX_RAMP;
         synth_q <= trpc_pkg::RST_SYNTH;
         cal_q <= trpc_pkg::RST_CAL & trpc_pkg::CAL_CFG_MASK;
         modem_q <= trpc_pkg::RST_MODEM;
         rdata_q <= 8'h00;
      end else begin
         tx_ramp_q <= tx_ramp_d;
         synth_q <= synth_d;
         cal_q <= cal_d;
         modem_q <= modem_d;
         rdata_q <= rdata_d;
      end
   end

   // ****************************************
   // Transmit sequencer
   // ****************************************
   trpc_pkg::trpc_tx_state_type tx_st_q, tx_st_d;
   logic [CW-1:0] tx_cnt_q, tx_cnt_d, pa_cnt_q, pa_cnt_d, ldo_cnt_q, ldo_cnt_d;
   logic pa_q, pa_d, mod_q, mod_d;
   logic pa_busy_q, pa_busy_d, ldo_busy_q, ldo_busy_d;
   logic [CW-1:0] mod_cyc;

   assign mod_cyc = CW'(32'(txmod_f) * 32'(trpc_pkg::TXMOD_STEP_CYC));

   always_comb begin
      tx_st_d = tx_st_q;
      tx_cnt_d = (tx_cnt_q != '0) ? tx_cnt_q - CW'(1) : tx_cnt_q;
      pa_cnt_d = (pa_cnt_q != '0) ? pa_cnt_q - CW'(1) : pa_cnt_q;
      ldo_cnt_d = (ldo_cnt_q != '0) ? ldo_cnt_q - CW'(1) : ldo_cnt_q;
      pa_d = pa_q;
      mod_d = mod_q;
      case (tx_st_q)
         trpc_pkg::TRPC_TX_IDLE: begin
            if (tx_request) begin
               pa_d = 1'b1;
               pa_cnt_d = ramp_cycles(tx_ramp_q[trpc_pkg::TXRAMP_LSB +: trpc_pkg::RAMP_W]);
               ldo_cnt_d = ramp_cycles(tx_ramp_q[trpc_pkg::LDO_LSB +: trpc_pkg::RAMP_W]);
               tx_cnt_d = mod_cyc;
               if (mod_cyc == '0) begin
                  mod_d = 1'b1;
                  tx_st_d = trpc_pkg::TRPC_TX_MOD;
               end else begin
                  tx_st_d = trpc_pkg::TRPC_TX_DELAY;
               end
            end
         end
         trpc_pkg::TRPC_TX_DELAY: begin
            if (!tx_request) begin
               tx_cnt_d = mod_cyc;
               tx_st_d = trpc_pkg::TRPC_TX_DOWN;
            end else if (tx_cnt_q <= CW'(1)) begin
               mod_d = 1'b1;
               tx_st_d = trpc_pkg::TRPC_TX_MOD;
            end
         end
         trpc_pkg::TRPC_TX_MOD: begin
            if (!tx_request) begin
               mod_d = 1'b0;
               tx_cnt_d = mod_cyc;
               if (mod_cyc == '0) begin
                  pa_d = 1'b0;
                  tx_st_d = trpc_pkg::TRPC_TX_IDLE;
               end else begin
                  tx_st_d = trpc_pkg::TRPC_TX_DOWN;
               end
            end
         end
         default: begin
            if (tx_cnt_q <= CW'(1)) begin
               pa_d = 1'b0;
               tx_st_d = trpc_pkg::TRPC_TX_IDLE;
            end
         end
      endcase
      pa_busy_d = (pa_cnt_d != '0);
      ldo_busy_d = (ldo_cnt_d != '0);
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         tx_st_q <= trpc_pkg::TRPC_TX_IDLE;
         tx_cnt_q <= '0;
         pa_cnt_q <= '0;
         ldo_cnt_q <= '0;
         pa_q <= 1'b0;
         mod_q <= 1'b0;
         pa_busy_q <= 1'b0;
         ldo_busy_q <= 1'b0;
      end else begin
         tx_st_q <= tx_st_d;
         tx_cnt_q <= tx_cnt_d;
         pa_cnt_q <= pa_cnt_d;
         ldo_cnt_q <= ldo_cnt_d;
         pa_q <= pa_d;
         mod_q <= mod_d;
         pa_busy_q <= pa_busy_d;
         ldo_busy_q <= ldo_busy_d;
      end
   end

   // ****************************************
   // Synthesizer settling and VCO calibration
   // ****************************************
   logic [CW-1:0] settle_cnt_q, settle_cnt_d;
   logic settled_q, settled_d;
   logic vco_force_ok;

   assign vco_force_ok = reg_write && hit(reg_addr, trpc_pkg::ADDR_CAL)
      && reg_wdata[trpc_pkg::CAL_VCO_FORCE] && chip_idle && synth_enabled;

   always_comb begin
      settle_cnt_d = (settle_cnt_q != '0) ? settle_cnt_q - CW'(1) : settle_cnt_q;
      if (vco_cal_finished) begin
         settle_cnt_d = CW'((32'(ts_f) + 32'(t0_f)) * 32'(trpc_pkg::SETTLE_STEP_CYC));
      end else if (synth_retune) begin
         settle_cnt_d = CW'(32'(ts_f) * 32'(trpc_pkg::SETTLE_STEP_CYC));
      end
      settled_d = (settle_cnt_d == '0);
      vco_run_d = vco_run_q;
      if (vco_cal_finished) begin
         vco_run_d = 1'b0;
      end
      if (vco_force_ok) begin
         vco_run_d = 1'b1;
      end
      if (idle_to_txrx && !cal_q[trpc_pkg::CAL_SKIP_VCO]) begin
         vco_run_d = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         settle_cnt_q <= '0;
         settled_q <= 1'b1;
         vco_run_q <= 1'b0;
      end else begin
         settle_cnt_q <= settle_cnt_d;
         settled_q <= settled_d;
         vco_run_q <= vco_run_d;
      end
   end

   // ****************************************
   // RC oscillator calibration
   // ****************************************
   logic [RC_W-1:0] rc_cnt_q, rc_cnt_d;
   logic [FINE_W-1:0] fine_cnt_q, fine_cnt_d;
   logic auto_q, auto_d;
   logic fine_fire, rc_force_req, rc_start;

   assign auto_d = wakeup_timer_enabled || wake_on_rx_state;
   assign rc_force_req = reg_write && hit(reg_addr, trpc_pkg::ADDR_CAL)
      && reg_wdata[trpc_pkg::CAL_RC_FORCE] && !rc_forced_q;

   always_comb begin
      fine_fire = 1'b0;
      fine_cnt_d = fine_cnt_q - FINE_W'(1);
      if (!cal_q[trpc_pkg::CAL_FINE_EN]) begin
         fine_cnt_d = FINE_W'(FINE_PERIOD_CYCLES);
      end else if (fine_cnt_q == '0) begin
         fine_fire = 1'b1;
         fine_cnt_d = FINE_W'(FINE_PERIOD_CYCLES);
      end
      rc_start = rc_osc_enabled && !rc_active_q
         && (rc_force_req || fine_fire || (auto_d && !auto_q));
      rc_cnt_d = rc_cnt_q;
      rc_active_d = rc_active_q;
      rc_forced_d = rc_forced_q;
      if (rc_active_q) begin
         rc_cnt_d = rc_cnt_q - RC_W'(1);
         if (rc_cnt_q <= RC_W'(1)) begin
            rc_active_d = 1'b0;
            rc_forced_d = 1'b0;
         end
      end
      if (rc_start) begin
         rc_active_d = 1'b1;
         rc_cnt_d = RC_W'(RC_CAL_CYCLES);
         rc_forced_d = rc_force_req;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         rc_cnt_q <= '0;
         fine_cnt_q <= '0;
         auto_q <= 1'b0;
         rc_active_q <= 1'b0;
         rc_forced_q <= 1'b0;
      end else begin
         rc_cnt_q <= rc_cnt_d;
         fine_cnt_q <= fine_cnt_d;
         auto_q <= auto_d;
         rc_active_q <= rc_active_d;
         rc_forced_q <= rc_forced_d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign reg_rdata = rdata_q;
   assign pa_enable = pa_q;
   assign tx_modulation = mod_q;
   assign pa_ramp_busy = pa_busy_q;
   assign ldo_ramp_busy = ldo_busy_q;
   assign synth_settled = settled_q;
   assign vco_cal_run = vco_run_q;
   assign vco_cal_double = cal_q[trpc_pkg::CAL_VCO_DP];
   assign rc_cal_active = rc_active_q;
   assign xtal_wake_half = cal_q[trpc_pkg::CAL_XTAL_HALF];
   assign bcr_comp_bypass = modem_q[trpc_pkg::MT_BCR_BYP];
   assign slicer_comp_bypass = modem_q[trpc_pkg::MT_SLIC_BYP];
   assign dither_symmetric = modem_q[trpc_pkg::MT_DITHER_TYPE];
   assign afc_polarity = modem_q[trpc_pkg::MT_AFC_POL];
   assign dsm_ref_10mhz = modem_q[trpc_pkg::MT_REF_SEL];
   assign dsm_ref_invert = modem_q[trpc_pkg::MT_REF_INV];
   assign iq_swap = modem_q[trpc_pkg::MT_IQ_SWAP];

   // ****************************************
   // Assertions
   // ****************************************
   logic [CW-1:0] since_pa_q;

   always_ff @(posedge clock) begin
      if (reset || (pa_d && !pa_q)) begin
         since_pa_q <= '0;
      end else if (since_pa_q != '1) begin
         since_pa_q <= since_pa_q + CW'(1);
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   sequence s_cal_write(int bitpos);
      reg_write && hit(reg_addr, trpc_pkg::ADDR_CAL) && reg_wdata[bitpos];
   endsequence

   a_mod_delay: assert property ($rose(mod_q) && $past(tx_st_q) == trpc_pkg::TRPC_TX_DELAY
      |-> since_pa_q == mod_cyc) else $error("Modulation delay wrong");
   a_ldo_ramp_len: assert property ($fell(ldo_ramp_busy) && pa_q
      |-> since_pa_q == ramp_cycles(tx_ramp_q[trpc_pkg::LDO_LSB +: trpc_pkg::RAMP_W]))
      else $error("Regulator ramp length wrong");
   a_pa_ramp_len: assert property ($fell(pa_ramp_busy) && pa_q
      |-> since_pa_q == ramp_cycles(tx_ramp_q[trpc_pkg::TXRAMP_LSB +: trpc_pkg::RAMP_W]))
      else $error("PA ramp length wrong");
   a_cold_settle: assert property (vco_cal_finished |=> !settled_q
      == ((32'(ts_f) + 32'(t0_f)) != 0) && settle_cnt_q
      == CW'((32'(ts_f) + 32'(t0_f)) * 32'(trpc_pkg::SETTLE_STEP_CYC)))
      else $error("Cold start settle load wrong");
   a_retune_settle: assert property (synth_retune && !vco_cal_finished |=> settle_cnt_q
      == CW'(32'(ts_f) * 32'(trpc_pkg::SETTLE_STEP_CYC))) else $error("Retune settle wrong");
   a_settle_reset: assert property ($fell(reset) |-> synth_q == trpc_pkg::RST_SYNTH
      || $past(reg_write)) else $error("Settle register reset wrong");
   a_vco_force: assert property (s_cal_write(trpc_pkg::CAL_VCO_FORCE) ##0 chip_idle
      && synth_enabled |=> vco_run_q) else $error("VCO force not taken");
   a_vco_skip: assert property (!vco_run_q && idle_to_txrx && cal_q[trpc_pkg::CAL_SKIP_VCO]
      && !vco_force_ok |=> !vco_run_q) else $error("VCO cal not skipped");
   a_rc_force: assert property (s_cal_write(trpc_pkg::CAL_RC_FORCE) ##0 !rc_forced_q
      && !rc_active_q && rc_osc_enabled |=> (rc_active_q && rc_forced_q) [*2])
      else $error("RC force not started");
   a_rc_needs_osc: assert property (!rc_osc_enabled && !rc_active_q |=> !rc_active_q)
      else $error("RC cal without oscillator");
   a_adc_done_read: assert property (reg_read && hit(reg_addr, trpc_pkg::ADDR_CAL)
      && adc_cal_done |=> rdata_q[trpc_pkg::CAL_ADC_DONE]) else $error("ADC done not read");

endmodule // trpc_tx_ramp_pll_cal_control

//--- trpc_tx_ramp_pll_cal_control_test.sv
`timescale 1ns/100ps
module trpc_tx_ramp_pll_cal_control_test;
   // ****************************************
   // Stimulus and monitor state
   // ****************************************
   localparam int RC_N = 20;
   localparam int FINE_N = 50;
   logic clock, reset, reg_write, reg_read, tx_request, chip_idle, synth_enabled;
   logic adc_cal_done, rc_osc_enabled, wakeup_timer_enabled, wake_on_rx_state, rd_q;
   logic [2:0] pul;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
   logic pa_enable, tx_modulation, pa_ramp_busy, ldo_ramp_busy, synth_settled, vco_cal_run;
   logic vco_cal_double, rc_cal_active, xtal_wake_half, bcr_comp_bypass, slicer_comp_bypass;
   logic dither_symmetric, afc_polarity, dsm_ref_10mhz, dsm_ref_invert, iq_swap;
   logic [6:0] mon;
   logic [7:0] exp_q[$];
   int mismatches, tests_run, cycles, a, b, c, n;
   int seed = 32'h2283491F;

   trpc_tx_ramp_pll_cal_control #(.RC_CAL_CYCLES(RC_N), .FINE_PERIOD_CYCLES(FINE_N)) dut_u (
      .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .tx_request(tx_request), .chip_idle(chip_idle), .synth_enabled(synth_enabled),
      .idle_to_txrx(pul[0]), .synth_retune(pul[1]), .vco_cal_finished(pul[2]),
      .adc_cal_done(adc_cal_done), .rc_osc_enabled(rc_osc_enabled),
      .wakeup_timer_enabled(wakeup_timer_enabled), .wake_on_rx_state(wake_on_rx_state),
      .pa_enable(pa_enable), .tx_modulation(tx_modulation), .pa_ramp_busy(pa_ramp_busy),
      .ldo_ramp_busy(ldo_ramp_busy), .synth_settled(synth_settled),
      .vco_cal_run(vco_cal_run), .vco_cal_double(vco_cal_double),
      .rc_cal_active(rc_cal_active), .xtal_wake_half(xtal_wake_half),
      .bcr_comp_bypass(bcr_comp_bypass), .slicer_comp_bypass(slicer_comp_bypass),
      .dither_symmetric(dither_symmetric), .afc_polarity(afc_polarity),
      .dsm_ref_10mhz(dsm_ref_10mhz), .dsm_ref_invert(dsm_ref_invert), .iq_swap(iq_swap)
   );

   assign mon = {synth_settled, rc_cal_active, vco_cal_run, ldo_ramp_busy, pa_ramp_busy,
      tx_modulation, pa_enable};

   // ****************************************
   // Checking and reporting
   // ****************************************
   task automatic final_report();
      $display("Mismatches %0d, checks %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] s, input logic [15:0] e, input string nm);
      tests_run++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic near(input int s, input int e, input string nm);
      check(16'((s >= e - 2 && s <= e + 2) ? e : s), 16'(e), nm);
   endtask

   always @(posedge clock) begin
      rd_q <= reg_read;
      cycles++;
      if (cycles == 60000) begin
         mismatches++;
         final_report();
      end
   end

   // Read data stands in the cycle after the strobe only
   always @(negedge clock) begin
      if (rd_q === 1'b1) begin
         if (exp_q.size() == 0) begin
            check({8'h00, reg_rdata}, 16'hFFFF, "unexpected read");
         end else begin
            check({8'h00, reg_rdata}, {8'h00, exp_q.pop_front()}, "reg_rdata");
         end
      end
   end

   // ****************************************
   // Bus and signal tasks
   // ****************************************
   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      @(posedge clock);
      reg_write <= 1'b1;
      reg_addr <= ad;
      reg_wdata <= d;
      @(posedge clock);
      reg_write <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] ad, input logic [7:0] e);
      @(posedge clock);
      reg_read <= 1'b1;
      reg_addr <= ad;
      exp_q.push_back(e);
      @(posedge clock);
      reg_read <= 1'b0;
      #1;
   endtask

   task automatic pulse(input int i);
      @(posedge clock);
      pul[i] <= 1'b1;
      @(posedge clock);
      pul <= 3'h0;
      #1;
   endtask

   task automatic count(input int sel, input logic val, output int k);
      k = 0;
      while (mon[sel] !== val && k < 9000) begin
         @(posedge clock);
         #1;
         k++;
      end
   endtask

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {reset, rd_q} = 2'b10;
      {reg_write, reg_read, tx_request, chip_idle, synth_enabled} = 5'h00;
      {adc_cal_done, rc_osc_enabled, wakeup_timer_enabled, wake_on_rx_state} = 4'h0;
      {pul, reg_addr, reg_wdata} = 19'h0;
      repeat (6) @(posedge clock);
      reset <= 1'b0;
      rd(trpc_pkg::ADDR_TX_RAMP, 8'h00);
      rd(trpc_pkg::ADDR_SYNTH, 8'h52);
      rd(trpc_pkg::ADDR_CAL, 8'h04);
      rd(trpc_pkg::ADDR_MODEM, 8'h00);
      rd(8'h54, 8'h00);
      repeat (4) begin
         v = 8'($random(seed));
         wr(trpc_pkg::ADDR_MODEM, v);
         rd(trpc_pkg::ADDR_MODEM, v);
         check({9'h0, bcr_comp_bypass, slicer_comp_bypass, dither_symmetric, afc_polarity,
            dsm_ref_10mhz, dsm_ref_invert, iq_swap}, {9'h0, v[7:4], v[2:0]}, "modem");
      end
      wr(trpc_pkg::ADDR_MODEM, trpc_pkg::RST_MODEM);
      check({15'h0, afc_polarity}, 16'h0, "afc default");
      @(posedge clock);
      adc_cal_done <= 1'b1;
      wr(trpc_pkg::ADDR_CAL, 8'h45);
      rd(trpc_pkg::ADDR_CAL, 8'h65);
      check({14'h0, xtal_wake_half, vco_cal_double}, 16'h3, "cal outputs");
      pulse(0);
      check(vco_cal_run, 1'b0, "skip vco");
      wr(trpc_pkg::ADDR_CAL, 8'hA0);
      rd(trpc_pkg::ADDR_CAL, 8'h20);
      pulse(0);
      check(vco_cal_run, 1'b1, "vco on entry");
      wr(trpc_pkg::ADDR_SYNTH, 8'h0B);
      pulse(2);
      check({vco_cal_run, synth_settled}, 2'b00, "cal done");
      count(6, 1'b1, n);
      near(n, 4000, "cold settle");
      pulse(1);
      count(6, 1'b1, n);
      near(n, 1000, "retune settle");
      rd(trpc_pkg::ADDR_SYNTH, 8'h0B);
      wr(trpc_pkg::ADDR_CAL, 8'h02);
      rd(trpc_pkg::ADDR_CAL, 8'h20);
      @(posedge clock);
      chip_idle <= 1'b1;
      synth_enabled <= 1'b1;
      wr(trpc_pkg::ADDR_CAL, 8'h02);
      rd(trpc_pkg::ADDR_CAL, 8'h22);
      pulse(2);
      rd(trpc_pkg::ADDR_CAL, 8'h20);
      wr(trpc_pkg::ADDR_CAL, 8'h08);
      check(rc_cal_active, 1'b0, "rc osc off");
      rd(trpc_pkg::ADDR_CAL, 8'h20);
      @(posedge clock);
      rc_osc_enabled <= 1'b1;
      wr(trpc_pkg::ADDR_CAL, 8'h08);
      fork
         count(5, 1'b0, n);
         rd(trpc_pkg::ADDR_CAL, 8'h28);
      join
      near(n, RC_N, "rc force");
      rd(trpc_pkg::ADDR_CAL, 8'h20);
      @(posedge clock);
      wakeup_timer_enabled <= 1'b1;
      count(5, 1'b1, n);
      count(5, 1'b0, n);
      near(n, RC_N, "rc wake timer");
      @(posedge clock);
      wakeup_timer_enabled <= 1'b0;
      @(posedge clock);
      wake_on_rx_state <= 1'b1;
      count(5, 1'b1, a);
      near(a, 1, "rc wor start");
      count(5, 1'b0, n);
      wr(trpc_pkg::ADDR_CAL, 8'h10);
      count(5, 1'b1, n);
      near(n, FINE_N, "rc fine");
      wr(trpc_pkg::ADDR_CAL, 8'h00);
      for (int i = 0; i < 3; i++) begin
         v = (i == 0) ? 8'h00 : (i == 1) ? 8'h7F : 8'($random(seed)) & 8'h7F;
         wr(trpc_pkg::ADDR_TX_RAMP, v);
         rd(trpc_pkg::ADDR_TX_RAMP, v);
         @(posedge clock);
         tx_request <= 1'b1;
         count(0, 1'b1, n);
         fork
            count(1, 1'b1, a);
            count(2, 1'b0, b);
            count(3, 1'b0, c);
         join
         near(a, int'(v[6:4]) * 400, "mod delay");
         near(b, (int'(v[1:0]) + 1) * 500, "pa ramp");
         near(c, (int'(v[3:2]) + 1) * 500, "ldo ramp");
         @(posedge clock);
         tx_request <= 1'b0;
         count(1, 1'b0, a);
         count(0, 1'b0, b);
         near(a + b, int'(v[6:4]) * 400 + 1, "ramp down");
      end
      repeat (3) @(posedge clock);
      final_report();
   end
endmodule // trpc_tx_ramp_pll_cal_control_test
